// File: hw/rsa_alu.sv
// execution datapath for the rotate, subtract, skip, set and swap group
`timescale 1ns/1ns
`default_nettype none
module rsa_alu (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic op_valid,
    input wire logic [rsa_pkg::OP_W-1:0] op_code,
    input wire logic [rsa_pkg::SEL_W-1:0] bit_sel,
    input wire logic [rsa_pkg::DATA_W-1:0] mem_rdata,
    input wire logic [rsa_pkg::DATA_W-1:0] imm_data,
    output logic op_ready,
    output logic [rsa_pkg::DATA_W-1:0] working_register,
    output logic borrow_inverse_flag,
    output logic result_nil_flag,
    output logic nibble_half_flag,
    output logic signed_wrap_flag,
    output logic [rsa_pkg::DATA_W-1:0] mem_wdata,
    output logic mem_we,
    output logic skip_next,
    output logic dummy_slot,
    output logic op_done
);
    rsa_dp_if dp ();

    rsa_subtract u_sub (
        .dp(dp.sub)
    );

    rsa_shifter u_shf (
        .dp(dp.shf)
    );

    rsa_pkg::rsa_state_t state_r;
    rsa_pkg::rsa_state_t state_nxt;
    rsa_pkg::rsa_op_t op;

    logic [rsa_pkg::DATA_W-1:0] w_r;
    logic [rsa_pkg::DATA_W-1:0] w_nxt;
    logic c_r;
    logic c_nxt;
    logic z_r;
    logic z_nxt;
    logic ac_r;
    logic ac_nxt;
    logic ov_r;
    logic ov_nxt;
    logic [rsa_pkg::DATA_W-1:0] wdata_r;
    logic [rsa_pkg::DATA_W-1:0] wdata_nxt;
    logic we_r;
    logic we_nxt;
    logic skip_r;
    logic skip_nxt;
    logic dummy_r;
    logic dummy_nxt;
    logic done_r;
    logic done_nxt;
    logic use_imm;
    logic take;
    logic two_cycle;
    logic [rsa_pkg::DATA_W-1:0] sub_res;
    logic plain_sub;

    assign op = rsa_pkg::rsa_op_t'(op_code);
    assign take = op_valid && (state_r == rsa_pkg::ST_EXEC);
    // new work is refused during the dummy slot of a skip instruction
    assign op_ready = (state_r == rsa_pkg::ST_EXEC);

    assign use_imm = (op == rsa_pkg::OP_MINUS_IMM_W);
    assign dp.opa = w_r;
    assign dp.opb = use_imm ? imm_data : mem_rdata;
    assign dp.mem = mem_rdata;
    // plain subtract takes no borrow
    // the unit always subtracts not(cin), so a forced one cancels it;
    // rotations still see the real carry since they never match here
    assign plain_sub = (op == rsa_pkg::OP_MINUS_W) || (op == rsa_pkg::OP_MINUS_MEM)
        || (op == rsa_pkg::OP_MINUS_IMM_W);
    assign dp.cin = plain_sub ? 1'b1 : c_r;
    assign dp.bsel = bit_sel;
    assign sub_res = dp.sub_res;

    always_comb begin
        two_cycle = 1'b0;
        unique case (op)
            rsa_pkg::OP_DEC_SKIP_NIL,
            rsa_pkg::OP_DEC_W_SKIP_NIL,
            rsa_pkg::OP_INC_SKIP_NIL,
            rsa_pkg::OP_INC_W_SKIP_NIL,
            rsa_pkg::OP_SKIP_IF_BIT_SET: begin
                two_cycle = 1'b1;
            end
            default: begin
                two_cycle = 1'b0;
            end
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        dummy_nxt = 1'b0;
        unique case (state_r)
            rsa_pkg::ST_EXEC: begin
                if (take && two_cycle) begin
                    state_nxt = rsa_pkg::ST_DUMMY;
                    dummy_nxt = 1'b1;
                end
            end
            rsa_pkg::ST_DUMMY: begin
                state_nxt = rsa_pkg::ST_EXEC;
            end
            default: begin
                state_nxt = rsa_pkg::ST_EXEC;
            end
        endcase
    end

    always_comb begin
        w_nxt = w_r;
        c_nxt = c_r;
        z_nxt = z_r;
        ac_nxt = ac_r;
        ov_nxt = ov_r;
        wdata_nxt = wdata_r;
        we_nxt = 1'b0;
        skip_nxt = 1'b0;
        done_nxt = 1'b0;
        if (take) begin
            done_nxt = 1'b1;
            unique case (op)
                rsa_pkg::OP_ROT_LEFT_CY_W: begin
                    w_nxt = dp.rlc_res;
                    c_nxt = mem_rdata[rsa_pkg::MSB];
                end
                rsa_pkg::OP_ROT_RIGHT_MEM: begin
                    wdata_nxt = dp.rr_res;
                    we_nxt = 1'b1;
                end
                rsa_pkg::OP_ROT_RIGHT_W: begin
                    w_nxt = dp.rr_res;
                end
                rsa_pkg::OP_ROT_RIGHT_CY: begin
                    wdata_nxt = dp.rrc_res;
                    we_nxt = 1'b1;
                    c_nxt = mem_rdata[0];
                end
                rsa_pkg::OP_ROT_RIGHT_CY_W: begin
                    w_nxt = dp.rrc_res;
                    c_nxt = mem_rdata[0];
                end
                rsa_pkg::OP_SUB_BORROW_W: begin
                    w_nxt = sub_res;
                    c_nxt = dp.sub_c;
                    z_nxt = (sub_res == rsa_pkg::ZERO);
                    ac_nxt = dp.sub_ac;
                    ov_nxt = dp.sub_ov;
                end
                rsa_pkg::OP_SUB_BORROW_MEM: begin
                    wdata_nxt = sub_res;
                    we_nxt = 1'b1;
                    c_nxt = dp.sub_c;
                    z_nxt = (sub_res == rsa_pkg::ZERO);
                    ac_nxt = dp.sub_ac;
                    ov_nxt = dp.sub_ov;
                end
                rsa_pkg::OP_MINUS_W,
                rsa_pkg::OP_MINUS_IMM_W: begin
                    w_nxt = sub_res;
                    c_nxt = dp.sub_c;
                    z_nxt = (sub_res == rsa_pkg::ZERO);
                    ac_nxt = dp.sub_ac;
                    ov_nxt = dp.sub_ov;
                end
                rsa_pkg::OP_MINUS_MEM: begin
                    wdata_nxt = sub_res;
                    we_nxt = 1'b1;
                    c_nxt = dp.sub_c;
                    z_nxt = (sub_res == rsa_pkg::ZERO);
                    ac_nxt = dp.sub_ac;
                    ov_nxt = dp.sub_ov;
                end
                rsa_pkg::OP_DEC_SKIP_NIL: begin
                    wdata_nxt = dp.dec_res;
                    we_nxt = 1'b1;
                    skip_nxt = (dp.dec_res == rsa_pkg::ZERO);
                end
                rsa_pkg::OP_DEC_W_SKIP_NIL: begin
                    w_nxt = dp.dec_res;
                    skip_nxt = (dp.dec_res == rsa_pkg::ZERO);
                end
                rsa_pkg::OP_INC_SKIP_NIL: begin
                    wdata_nxt = dp.inc_res;
                    we_nxt = 1'b1;
                    skip_nxt = (dp.inc_res == rsa_pkg::ZERO);
                end
                rsa_pkg::OP_INC_W_SKIP_NIL: begin
                    w_nxt = dp.inc_res;
                    skip_nxt = (dp.inc_res == rsa_pkg::ZERO);
                end
                rsa_pkg::OP_SKIP_IF_BIT_SET: begin
                    skip_nxt = dp.bit_val;
                end
                rsa_pkg::OP_SET_BYTE: begin
                    wdata_nxt = rsa_pkg::ALL_ONES;
                    we_nxt = 1'b1;
                end
                rsa_pkg::OP_SET_BIT: begin
                    wdata_nxt = dp.setb_res;
                    we_nxt = 1'b1;
                end
                rsa_pkg::OP_SWAP_MEM: begin
                    wdata_nxt = dp.swap_res;
                    we_nxt = 1'b1;
                end
                rsa_pkg::OP_SWAP_W: begin
                    w_nxt = dp.swap_res;
                end
                default: begin
                    // unknown codes act as a no-op so the sequencer never hangs
                    done_nxt = 1'b1;
                end
            endcase
        end
    end

    // sequencer state
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_r <= rsa_pkg::ST_EXEC;
        end else begin
            state_r <= state_nxt;
        end
    end

    // accumulator
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            w_r <= rsa_pkg::W_RST;
        end else begin
            w_r <= w_nxt;
        end
    end

    // status flags
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            c_r <= rsa_pkg::FLAG_RST;
            z_r <= rsa_pkg::FLAG_RST;
            ac_r <= rsa_pkg::FLAG_RST;
            ov_r <= rsa_pkg::FLAG_RST;
        end else begin
            c_r <= c_nxt;
            z_r <= z_nxt;
            ac_r <= ac_nxt;
            ov_r <= ov_nxt;
        end
    end

    // memory write port
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wdata_r <= rsa_pkg::ZERO;
            we_r <= 1'b0;
        end else begin
            wdata_r <= wdata_nxt;
            we_r <= we_nxt;
        end
    end

    // one-cycle pulses to the sequencer
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            skip_r <= 1'b0;
            dummy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            skip_r <= skip_nxt;
            dummy_r <= dummy_nxt;
            done_r <= done_nxt;
        end
    end

    assign working_register = w_r;
    assign borrow_inverse_flag = c_r;
    assign result_nil_flag = z_r;
    assign nibble_half_flag = ac_r;
    assign signed_wrap_flag = ov_r;
    assign mem_wdata = wdata_r;
    assign mem_we = we_r;
    assign skip_next = skip_r;
    assign dummy_slot = dummy_r;
    assign op_done = done_r;
endmodule : rsa_alu
`default_nettype wire

// File: hw/rsa_pkg.sv
// constants, opcode and state types for the rotate/subtract/skip datapath
package rsa_pkg;
    localparam int DATA_W = 8;
    localparam int SEL_W = 3;
    localparam int NIB_W = 4;
    localparam int OP_W = 5;
    localparam logic [DATA_W-1:0] ALL_ONES = 8'hFF;
    localparam logic [DATA_W-1:0] ONE = 8'h01;
    localparam logic [DATA_W-1:0] ZERO = 8'h00;
    localparam logic [DATA_W-1:0] W_RST = 8'h00;
    localparam logic FLAG_RST = 1'b0;
    localparam int MSB = DATA_W - 1;

    typedef enum logic [OP_W-1:0] {
        OP_ROT_LEFT_CY_W = 5'h00,
        OP_ROT_RIGHT_MEM = 5'h01,
        OP_ROT_RIGHT_W = 5'h02,
        OP_ROT_RIGHT_CY = 5'h03,
        OP_ROT_RIGHT_CY_W = 5'h04,
        OP_SUB_BORROW_W = 5'h05,
        OP_SUB_BORROW_MEM = 5'h06,
        OP_MINUS_W = 5'h07,
        OP_MINUS_MEM = 5'h08,
        OP_MINUS_IMM_W = 5'h09,
        OP_DEC_SKIP_NIL = 5'h0A,
        OP_DEC_W_SKIP_NIL = 5'h0B,
        OP_INC_SKIP_NIL = 5'h0C,
        OP_INC_W_SKIP_NIL = 5'h0D,
        OP_SKIP_IF_BIT_SET = 5'h0E,
        OP_SET_BYTE = 5'h0F,
        OP_SET_BIT = 5'h10,
        OP_SWAP_MEM = 5'h11,
        OP_SWAP_W = 5'h12
    } rsa_op_t;

    typedef enum logic [1:0] {
        ST_EXEC = 2'h1,
        ST_DUMMY = 2'h2
    } rsa_state_t;
endpackage : rsa_pkg

// File: hw/rsa_dp_if.sv
// operand and result bundle between the core and its two datapath units
`timescale 1ns/1ns
`default_nettype none
interface rsa_dp_if;
    logic [rsa_pkg::DATA_W-1:0] opa;
    logic [rsa_pkg::DATA_W-1:0] opb;
    logic [rsa_pkg::DATA_W-1:0] mem;
    logic cin;
    logic [rsa_pkg::SEL_W-1:0] bsel;
    logic [rsa_pkg::DATA_W-1:0] sub_res;
    logic sub_c;
    logic sub_ac;
    logic sub_ov;
    logic [rsa_pkg::DATA_W-1:0] rr_res;
    logic [rsa_pkg::DATA_W-1:0] rrc_res;
    logic [rsa_pkg::DATA_W-1:0] rlc_res;
    logic [rsa_pkg::DATA_W-1:0] swap_res;
    logic [rsa_pkg::DATA_W-1:0] inc_res;
    logic [rsa_pkg::DATA_W-1:0] dec_res;
    logic [rsa_pkg::DATA_W-1:0] setb_res;
    logic bit_val;
    modport core (output opa, opb, mem, cin, bsel,
        input sub_res, sub_c, sub_ac, sub_ov, rr_res, rrc_res, rlc_res,
        input swap_res, inc_res, dec_res, setb_res, bit_val);
    modport sub (input opa, opb, cin, output sub_res, sub_c, sub_ac, sub_ov);
    modport shf (input mem, cin, bsel,
        output rr_res, rrc_res, rlc_res, swap_res, inc_res, dec_res, setb_res, bit_val);
endinterface : rsa_dp_if
`default_nettype wire

// File: hw/rsa_subtract.sv
// borrow subtractor: a - b - not(cin) with the carry, half-carry and overflow flags
`timescale 1ns/1ns
`default_nettype none
module rsa_subtract (
    rsa_dp_if.sub dp
);
    logic [rsa_pkg::DATA_W:0] full;
    logic [rsa_pkg::NIB_W:0] half;
    logic [rsa_pkg::DATA_W-1:0] nb;
    assign nb = ~dp.opb;
    assign full = {1'b0, dp.opa} + {1'b0, nb} + {{rsa_pkg::DATA_W{1'b0}}, dp.cin};
    assign half = {1'b0, dp.opa[rsa_pkg::NIB_W-1:0]} + {1'b0, nb[rsa_pkg::NIB_W-1:0]}
        + {{rsa_pkg::NIB_W{1'b0}}, dp.cin};
    assign dp.sub_res = full[rsa_pkg::DATA_W-1:0];
    assign dp.sub_c = full[rsa_pkg::DATA_W];
    assign dp.sub_ac = half[rsa_pkg::NIB_W];
    // signed wrap: operands differ in sign and result sign left minuend's
    assign dp.sub_ov = (dp.opa[rsa_pkg::MSB] ^ dp.opb[rsa_pkg::MSB])
        & (dp.opa[rsa_pkg::MSB] ^ full[rsa_pkg::MSB]);
endmodule : rsa_subtract
`default_nettype wire

// File: hw/rsa_shifter.sv
// rotate, swap, increment, decrement and bit set/test on the memory byte
`timescale 1ns/1ns
`default_nettype none
module rsa_shifter (
    rsa_dp_if.shf dp
);
    logic [rsa_pkg::DATA_W-1:0] mask;
    localparam int N = rsa_pkg::NIB_W;
    assign dp.rr_res = {dp.mem[0], dp.mem[rsa_pkg::MSB:1]};
    assign dp.rrc_res = {dp.cin, dp.mem[rsa_pkg::MSB:1]};
    assign dp.rlc_res = {dp.mem[rsa_pkg::MSB-1:0], dp.cin};
    assign dp.swap_res = {dp.mem[N-1:0], dp.mem[rsa_pkg::MSB:N]};
    assign dp.inc_res = dp.mem + rsa_pkg::ONE;
    assign dp.dec_res = dp.mem - rsa_pkg::ONE;
    genvar i;
    for (i = 0; i < rsa_pkg::DATA_W; i++) begin : g_mask
        assign mask[i] = (dp.bsel == rsa_pkg::SEL_W'(i));
    end
    assign dp.setb_res = dp.mem | mask;
    assign dp.bit_val = |(dp.mem & mask);
endmodule : rsa_shifter
`default_nettype wire

// File: test/rsa_alu_asserts.sv
// port-level checks for the rotate/subtract/skip datapath
`timescale 1ns/1ns
`default_nettype none
module rsa_alu_asserts (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic op_valid,
    input wire logic [4:0] op_code,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] imm_data,
    input wire logic op_ready,
    input wire logic [7:0] working_register,
    input wire logic borrow_inverse_flag,
    input wire logic result_nil_flag,
    input wire logic nibble_half_flag,
    input wire logic signed_wrap_flag,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_we,
    input wire logic skip_next,
    input wire logic dummy_slot,
    input wire logic op_done
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    wire logic tk;
    logic bit_r;
    assign tk = op_valid && op_ready;
    // selected bit kept one cycle, avoids an indexed past value
    always_ff @(posedge ref_clk) bit_r <= mem_rdata[bit_sel];
    property p_done; tk |=> op_done; endproperty
    a_done: assert property (p_done) else $error("no completion after a taken request");
    property p_slot; tk && op_code inside {[5'h0A:5'h0E]} |=> dummy_slot && !op_ready ##1 op_ready && !dummy_slot; endproperty
    a_slot: assert property (p_slot) else $error("skip op not two cycles");
    property p_rlc; tk && op_code == 5'h00 |=> {borrow_inverse_flag, working_register} == {$past(mem_rdata), $past(borrow_inverse_flag)} && !mem_we; endproperty
    a_rlc: assert property (p_rlc) else $error("left rotate through carry wrong");
    property p_rrm; tk && op_code == 5'h01 |=> mem_we && {mem_wdata[6:0], mem_wdata[7]} == $past(mem_rdata) && $stable(borrow_inverse_flag); endproperty
    a_rrm: assert property (p_rrm) else $error("right rotate of memory wrong");
    property p_sub; tk && op_code == 5'h07 |=> borrow_inverse_flag == ($past(working_register) >= $past(mem_rdata)); endproperty
    a_sub: assert property (p_sub) else $error("subtract carry wrong");
    property p_dec; tk && op_code == 5'h0A |=> mem_we && mem_wdata == $past(mem_rdata) - 8'h01 && skip_next == (mem_wdata == 8'h00); endproperty
    a_dec: assert property (p_dec) else $error("decrement skip wrong");
    property p_incw; tk && op_code == 5'h0D |=> working_register == $past(mem_rdata) + 8'h01 && skip_next == (working_register == 8'h00) && !mem_we; endproperty
    a_incw: assert property (p_incw) else $error("increment into w wrong");
    property p_bit; tk && op_code == 5'h0E |=> skip_next == bit_r && $stable(borrow_inverse_flag); endproperty
    a_bit: assert property (p_bit) else $error("bit skip wrong");
    property p_set; tk && op_code == 5'h0F |=> mem_we && mem_wdata == 8'hFF; endproperty
    a_set: assert property (p_set) else $error("byte set wrong");
    property p_swp; tk && op_code == 5'h12 |=> {working_register[3:0], working_register[7:4]} == $past(mem_rdata) && !mem_we; endproperty
    a_swp: assert property (p_swp) else $error("nibble swap into w wrong");
endmodule : rsa_alu_asserts
bind rsa_alu rsa_alu_asserts rsa_alu_asserts_i (.ref_clk, .resetn, .op_valid, .op_code, .bit_sel, .mem_rdata,
    .imm_data, .op_ready, .working_register, .borrow_inverse_flag, .result_nil_flag, .nibble_half_flag,
    .signed_wrap_flag, .mem_wdata, .mem_we, .skip_next, .dummy_slot, .op_done);
`default_nettype wire

// File: test/rsa_alu_tb_top.sv
// self-checking bench for the rotate/subtract/skip datapath
`timescale 1ns/1ns
`default_nettype none
module rsa_alu_tb_top;
    logic ref_clk, resetn, op_valid, op_ready, c_f, z_f, ac_f, ov_f, mem_we, skip_next, dummy_slot, op_done;
    logic [4:0] op_code;
    logic [2:0] bit_sel;
    logic [7:0] mem_rdata, imm_data, working_register, mem_wdata, m_w;
    logic m_c, m_z, m_ac, m_ov;
    logic [21:0] exp_q[$];
    logic [21:0] e;
    logic [31:0] seed;
    int fails, comparisons, cyc;

    rsa_alu rsa_alu_i (.ref_clk(ref_clk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code),
        .bit_sel(bit_sel), .mem_rdata(mem_rdata), .imm_data(imm_data), .op_ready(op_ready),
        .working_register(working_register), .borrow_inverse_flag(c_f), .result_nil_flag(z_f),
        .nibble_half_flag(ac_f), .signed_wrap_flag(ov_f), .mem_wdata(mem_wdata), .mem_we(mem_we),
        .skip_next(skip_next), .dummy_slot(dummy_slot), .op_done(op_done));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic complete_run();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // result, carry, zero, half, overflow of a - b - not(ci)
    function automatic logic [11:0] sub8(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'h0, a} + {1'h0, ~b} + {8'h00, ci};
        h = {1'h0, a[3:0]} + {1'h0, ~b[3:0]} + {4'h0, ci};
        return {s[7:0], s[8], s[7:0] == 8'h00, h[4], (a[7] != b[7]) && (s[7] != a[7])};
    endfunction : sub8

    // drive one request and note its expected outcome
    task automatic issue(input logic [4:0] op, input logic [7:0] a, input logic [2:0] bs, input logic [7:0] imm);
        logic [7:0] wd;
        logic sk;
        logic [11:0] r;
        wd = 8'h00;
        sk = 1'h0;
        @(posedge ref_clk);
        op_valid <= 1'h1;
        op_code <= op;
        mem_rdata <= a;
        bit_sel <= bs;
        imm_data <= imm;
        case (op)
            5'h00: begin
                m_w = {a[6:0], m_c};
                m_c = a[7];
            end
            5'h01: wd = {a[0], a[7:1]};
            5'h02: m_w = {a[0], a[7:1]};
            5'h03: begin
                wd = {m_c, a[7:1]};
                m_c = a[0];
            end
            5'h04: begin
                m_w = {m_c, a[7:1]};
                m_c = a[0];
            end
            5'h05, 5'h06, 5'h07, 5'h08, 5'h09: begin
                r = sub8(m_w, op == 5'h09 ? imm : a, op > 5'h06 || m_c);
                {m_c, m_z, m_ac, m_ov} = r[3:0];
                if (op == 5'h06 || op == 5'h08) wd = r[11:4];
                else m_w = r[11:4];
            end
            5'h0A, 5'h0C: wd = op == 5'h0A ? a - 8'h01 : a + 8'h01;
            5'h0B, 5'h0D: m_w = op == 5'h0B ? a - 8'h01 : a + 8'h01;
            5'h0E: sk = a[bs];
            5'h0F: wd = 8'hFF;
            5'h10: wd = a | (8'h01 << bs);
            5'h11: wd = {a[3:0], a[7:4]};
            5'h12: m_w = {a[3:0], a[7:4]};
            default: ;
        endcase
        if (op inside {5'h0A, 5'h0C}) sk = wd == 8'h00;
        if (op inside {5'h0B, 5'h0D}) sk = m_w == 8'h00;
        exp_q.push_back({wd, m_w, m_c, m_z, m_ac, m_ov, op inside {5'h01, 5'h03, 5'h06, 5'h08, 5'h0A, 5'h0C,
            5'h0F, 5'h10, 5'h11}, sk});
        // a byte set offered in the dummy slot must be ignored
        if (op inside {[5'h0A:5'h0E]}) begin
            @(posedge ref_clk);
            op_code <= 5'h0F;
        end
    endtask : issue

    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 1000) begin
            fails++;
            complete_run();
        end
    end

    // scoreboard: oldest note against each completion
    always @(posedge ref_clk) begin
        if (resetn && op_done) begin
            if (exp_q.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                e = exp_q.pop_front();
                chk(working_register, e[13:6]);
                chk({c_f, z_f, ac_f, ov_f}, e[5:2]);
                chk({mem_we, e[1] ? mem_wdata : 8'h00}, {e[1], e[21:14]});
                chk(skip_next, e[0]);
            end
        end
    end

    initial begin
        resetn = 1'h0;
        op_valid = 1'h0;
        op_code = 5'h00;
        bit_sel = 3'h0;
        mem_rdata = 8'h00;
        imm_data = 8'h00;
        {m_w, m_c, m_z, m_ac, m_ov} = 12'h000;
        seed = 32'h3DE3;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'h1;
        #1 chk({working_register, c_f, z_f, ac_f, ov_f, mem_wdata, mem_we, skip_next, dummy_slot, op_done, op_ready},
            32'h1);
        $display("test reset done");
        // clear carry, then plain subtracts must add no borrow
        issue(5'h00, 8'h00, 3'h0, 8'h00);
        issue(5'h07, 8'h00, 3'h0, 8'h00);
        issue(5'h09, 8'h00, 3'h0, 8'h01);
        issue(5'h0A, 8'h01, 3'h0, 8'h00);
        issue(5'h0C, 8'hFF, 3'h0, 8'h00);
        issue(5'h0E, 8'h80, 3'h7, 8'h00);
        issue(5'h0E, 8'h7F, 3'h7, 8'h00);
        issue(5'h1F, 8'h55, 3'h0, 8'h00);
        $display("test boundaries done");
        repeat (12) begin
            for (int k = 0; k < 19; k++) begin
                seed = lfsr(seed);
                issue(k[4:0], seed[7:0], seed[10:8], seed[23:16]);
            end
        end
        @(posedge ref_clk);
        op_valid <= 1'h0;
        repeat (3) @(posedge ref_clk);
        chk(exp_q.size(), 32'h0);
        $display("test random done");
        complete_run();
    end
endmodule : rsa_alu_tb_top
`default_nettype wire
